// ===== verilog/timer_params.svh
// Constants of the quad gated timer unit: register offsets, field positions,
// reset values and timing counts. Assumes a 32-bit APB slave on pclk.
//
// Operation
// - Count source: chain, clock, clock/16, pin
// - Four timers, one input, one output each
// - Capture on rising, falling or both edges
// - Reference match drives an output event
// - Output event: low pulse or toggle
// - Timer pairs cascade into 32-bit counter
// - External gate holds off or restarts counting
// - First gate pair 1/2, second 3/4
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define OFS_CTRL        12'h000
`define OFS_GATE        12'h004
`define OFS_STATUS      12'h008
`define OFS_MASK        12'h00C
`define OFS_TIMER_BASE  12'h010
`define OFS_TIMER_STEP  12'h010
`define OFS_T_MODE      4'h0
`define OFS_T_REF       4'h4
`define OFS_T_CAP       4'h8
`define OFS_T_CNT       4'hC

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CTRL_EN_LSB     0
`define CTRL_CASC_LSB   4
`define GATE_EN_LSB     0
`define GATE_RST_LSB    4
`define STAT_REF_LSB    0
`define STAT_CAP_LSB    4

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_CTRL        6'h00
`define RST_GATE        8'h00
`define RST_MASK        8'h00
`define RST_MODE        6'h00
`define RST_REF         16'hFFFF
`define RST_CNT         16'h0000

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define PRESCALE_DIV    16
`define PRESCALE_MAX    4'hF

`endif

// ===== verilog/timer_pkg.sv
// Types of the quad gated timer unit.
// Assumes timer_params.svh supplies the numeric constants.
package timer_pkg;

  // --------------------------------------------------------------------------
  // Count sources and capture edges
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_CHAIN,
    SRC_CLOCK,
    SRC_CLOCK_DIV,
    SRC_PIN
  } source_type;

  typedef enum logic [1:0] {
    CAP_NONE,
    CAP_RISE,
    CAP_FALL,
    CAP_BOTH
  } capture_edge_type;

  // --------------------------------------------------------------------------
  // Carriers
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic             restart;
    logic             toggle;
    capture_edge_type cap_edge;
    source_type       src;
  } mode_type;

  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } pin_event_type;

endpackage

// ===== verilog/pin_sync.sv
// Three-stage pin synchroniser with registered edge pulses.
// Assumes an asynchronous pin; a change counts once stages two and three agree.
`timescale 1ns/10ps

module pin_sync
(
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    pin,
  output timer_pkg::pin_event_type     ev
);

  logic meta_q;
  logic sync2_q;
  logic sync3_q;
  logic stable_q;
  logic rise_q;
  logic fall_q;

  // --------------------------------------------------------------------------
  // Synchroniser chain
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q  <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end
    else
    begin
      meta_q  <= pin;
      sync2_q <= meta_q;
      sync3_q <= sync2_q;
    end
  end

  // --------------------------------------------------------------------------
  // Agreement filter and edges, one pulse per qualified change
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stable_q <= 1'b0;
      rise_q   <= 1'b0;
      fall_q   <= 1'b0;
    end
    else
    begin
      rise_q <= 1'b0;
      fall_q <= 1'b0;
      if (sync2_q == sync3_q && sync3_q != stable_q)
      begin
        stable_q <= sync3_q;
        rise_q   <= sync3_q;
        fall_q   <= !sync3_q;
      end
    end
  end

  assign ev.level = stable_q;
  assign ev.rise  = rise_q;
  assign ev.fall  = fall_q;

endmodule

// ===== verilog/quad_gated_timer_unit.sv
// Four 16-bit timers with capture, reference output, gating and cascade,
// reached over a zero-wait APB slave.
// Assumes pins are asynchronous to pclk; gate pins are active low.
`timescale 1ns/10ps
`include "timer_params.svh"

module quad_gated_timer_unit
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  timer_input_pins,
  input  wire logic        gate_pin_first_pair,
  input  wire logic        gate_pin_second_pair,
  output logic      [3:0]  timer_output_pins,
  output logic             irq
);

  localparam int NT = 4;

  logic [5:0]               ctrl_q;
  logic [7:0]               gate_cfg_q;
  logic [7:0]               status_q;
  logic [7:0]               mask_q;
  timer_pkg::mode_type      mode_q [NT];
  logic [15:0]              ref_q  [NT];
  logic [15:0]              cap_q  [NT];
  logic [15:0]              cnt_q  [NT];
  logic [3:0]               out_q;
  logic [3:0]               hit_q;
  logic [3:0]               presc_q;
  logic                     presc_tick;
  logic [31:0]              rdata_q;
  logic                     err_q;
  timer_pkg::pin_event_type tin_ev  [NT];
  timer_pkg::pin_event_type gate_ev [2];
  logic [3:0]               tick;
  logic [3:0]               run;
  logic [3:0]               hit;
  logic [3:0]               gate_restart;
  logic [3:0]               cap_hit;
  logic                     wr_en;
  logic                     setup;

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic logic edge_match(input timer_pkg::pin_event_type ev,
                                      input timer_pkg::capture_edge_type sel);
    logic m;
    m = 1'b0;
    unique case (sel)
      timer_pkg::CAP_NONE: m = 1'b0;
      timer_pkg::CAP_RISE: m = ev.rise;
      timer_pkg::CAP_FALL: m = ev.fall;
      timer_pkg::CAP_BOTH: m = ev.rise | ev.fall;
    endcase
    return m;
  endfunction

  function automatic logic timer_addr(input logic [11:0] a, input int idx, input logic [3:0] ofs);
    logic [11:0] base;
    base = `OFS_TIMER_BASE + 12'(idx) * `OFS_TIMER_STEP;
    return a == (base + {8'h00, ofs});
  endfunction

  function automatic logic cascaded(input logic [5:0] c, input int idx);
    return c[`CTRL_CASC_LSB + idx / 2];
  endfunction

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  for (genvar g = 0; g < NT; g++)
  begin : g_tin
    pin_sync u_tin
    (
      .pclk    (pclk),
      .presetn (presetn),
      .pin     (timer_input_pins[g]),
      .ev      (tin_ev[g])
    );
  end

  pin_sync u_gate_a
  (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (gate_pin_first_pair),
    .ev      (gate_ev[0])
  );

  pin_sync u_gate_b
  (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (gate_pin_second_pair),
    .ev      (gate_ev[1])
  );

  // --------------------------------------------------------------------------
  // Clock divided by sixteen
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      presc_q <= 4'h0;
    else
      presc_q <= presc_q + 4'h1;
  end

  assign presc_tick = (presc_q == `PRESCALE_MAX);

  // --------------------------------------------------------------------------
  // Count enables, gating and reference match
  // --------------------------------------------------------------------------
  always_comb
  begin
    for (int i = 0; i < NT; i++)
    begin
      // Chained sources use last cycle's match so no loop can form
      unique case (mode_q[i].src)
        timer_pkg::SRC_CHAIN:     tick[i] = hit_q[(i + NT - 1) % NT];
        timer_pkg::SRC_CLOCK:     tick[i] = 1'b1;
        timer_pkg::SRC_CLOCK_DIV: tick[i] = presc_tick;
        timer_pkg::SRC_PIN:       tick[i] = tin_ev[i].rise;
      endcase
      if ((i % 2) == 1 && cascaded(ctrl_q, i))
        tick[i] = hit_q[i - 1];
      // Gate pin low lets the governed timer count
      run[i] = ctrl_q[`CTRL_EN_LSB + i] && tick[i] &&
               !(gate_cfg_q[`GATE_EN_LSB + i] && gate_ev[i / 2].level);
      gate_restart[i] = gate_cfg_q[`GATE_EN_LSB + i] && gate_cfg_q[`GATE_RST_LSB + i] &&
                        gate_ev[i / 2].fall;
      hit[i] = run[i] && (cnt_q[i] == ref_q[i]);
      cap_hit[i] = ctrl_q[`CTRL_EN_LSB + i] && edge_match(tin_ev[i], mode_q[i].cap_edge);
    end
  end

  // --------------------------------------------------------------------------
  // APB decode
  // --------------------------------------------------------------------------
  assign setup  = psel && !penable;
  assign wr_en  = psel && penable && pwrite && !err_q;
  assign pready = 1'b1;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdata_q <= 32'h0000_0000;
      err_q   <= 1'b0;
    end
    else if (setup)
    begin
      rdata_q <= 32'h0000_0000;
      err_q   <= 1'b1;
      if (paddr == `OFS_CTRL)
      begin
        rdata_q <= {26'h000_0000, ctrl_q};
        err_q   <= 1'b0;
      end
      if (paddr == `OFS_GATE)
      begin
        rdata_q <= {24'h00_0000, gate_cfg_q};
        err_q   <= 1'b0;
      end
      if (paddr == `OFS_STATUS)
      begin
        rdata_q <= {24'h00_0000, status_q};
        err_q   <= 1'b0;
      end
      if (paddr == `OFS_MASK)
      begin
        rdata_q <= {24'h00_0000, mask_q};
        err_q   <= 1'b0;
      end
      for (int i = 0; i < NT; i++)
      begin
        if (timer_addr(paddr, i, `OFS_T_MODE))
        begin
          rdata_q <= {26'h000_0000, mode_q[i]};
          err_q   <= 1'b0;
        end
        if (timer_addr(paddr, i, `OFS_T_REF))
        begin
          rdata_q <= {16'h0000, ref_q[i]};
          err_q   <= 1'b0;
        end
        if (timer_addr(paddr, i, `OFS_T_CAP))
        begin
          rdata_q <= {16'h0000, cap_q[i]};
          err_q   <= 1'b0;
        end
        if (timer_addr(paddr, i, `OFS_T_CNT))
        begin
          rdata_q <= {16'h0000, cnt_q[i]};
          err_q   <= 1'b0;
        end
      end
      // Writes return zero so stale register contents never leak onto the bus
      if (pwrite)
        rdata_q <= 32'h0000_0000;
    end
  end

  assign prdata  = rdata_q;
  assign pslverr = psel && penable && err_q;

  // --------------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q     <= `RST_CTRL;
      gate_cfg_q <= `RST_GATE;
      mask_q     <= `RST_MASK;
      for (int i = 0; i < NT; i++)
      begin
        mode_q[i] <= `RST_MODE;
        ref_q[i]  <= `RST_REF;
      end
    end
    else if (wr_en)
    begin
      if (paddr == `OFS_CTRL)
        ctrl_q <= pwdata[5:0];
      if (paddr == `OFS_GATE)
        gate_cfg_q <= pwdata[7:0];
      if (paddr == `OFS_MASK)
        mask_q <= pwdata[7:0];
      for (int i = 0; i < NT; i++)
      begin
        if (timer_addr(paddr, i, `OFS_T_MODE))
          mode_q[i] <= pwdata[5:0];
        if (timer_addr(paddr, i, `OFS_T_REF))
          ref_q[i] <= pwdata[15:0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Counters; a software write wins over counting
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NT; i++)
        cnt_q[i] <= `RST_CNT;
    end
    else
    begin
      for (int i = 0; i < NT; i++)
      begin
        if (wr_en && timer_addr(paddr, i, `OFS_T_CNT))
          cnt_q[i] <= pwdata[15:0];
        else if (gate_restart[i])
          cnt_q[i] <= `RST_CNT;
        else if (hit[i] && mode_q[i].restart)
          cnt_q[i] <= `RST_CNT;
        else if (run[i])
          cnt_q[i] <= cnt_q[i] + 16'h0001;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Capture
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NT; i++)
        cap_q[i] <= 16'h0000;
    end
    else
    begin
      for (int i = 0; i < NT; i++)
        if (cap_hit[i])
          cap_q[i] <= cnt_q[i];
    end
  end

  // --------------------------------------------------------------------------
  // Timer outputs; a cascaded lower timer leaves its pin idle high
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_q <= 4'hF;
      hit_q <= 4'h0;
    end
    else
    begin
      hit_q <= hit;
      for (int i = 0; i < NT; i++)
      begin
        if ((i % 2) == 0 && cascaded(ctrl_q, i + 1))
          out_q[i] <= 1'b1;
        else if (mode_q[i].toggle)
          out_q[i] <= hit[i] ? !out_q[i] : out_q[i];
        else
          out_q[i] <= !hit[i];
      end
    end
  end

  assign timer_output_pins = out_q;

  // --------------------------------------------------------------------------
  // Event status and interrupt; a new event wins over a clear
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status_q <= 8'h00;
    else
    begin
      if (wr_en && paddr == `OFS_STATUS)
        status_q <= (status_q & ~pwdata[7:0]) | {cap_hit, hit};
      else
        status_q <= status_q | {cap_hit, hit};
    end
  end

  assign irq = |(status_q & mask_q);

endmodule

// ===== verilog/pin_sync_note_placeholder_removed.sv
// No logic here; the pin synchroniser lives in pin_sync.sv.

// ===== verification/quad_gated_timer_unit_props.sv
// Checker of the timer unit's APB and pin ports.
// Assumes binding to quad_gated_timer_unit, one clock.
`timescale 1ns/10ps
module quad_gated_timer_unit_props
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [3:0]  timer_output_pins,
  input wire logic        irq
);
  // --------------------------------------------------------------------------
  // Bus phases, interrupt mask and idle outputs after reset
  // --------------------------------------------------------------------------
  localparam logic [11:0] LAST = 12'h04C;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable;
  endsequence
  a_ready_no_wait: assert property (access_s |-> pready)
    else $error("pready low in access");
  a_err_in_access: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access");
  a_rdata_holds: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("prdata moved without setup");
  a_write_rdata_zero: assert property (psel && !penable && pwrite |=> prdata == 32'h0000_0000)
    else $error("prdata not zero on write");
  a_unmapped_err: assert property ((psel && !penable && paddr > LAST) ##1 access_s
    |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property ((psel && !penable && paddr <= LAST && paddr[1:0] == 2'h0) ##1 access_s
    |-> !pslverr)
    else $error("mapped access refused");
  a_mask_quiet: assert property (psel && penable && pwrite && paddr == 12'h00C && pwdata[7:0] == 8'h00
    |=> !irq)
    else $error("irq with empty mask");
  a_out_idle: assert property ($rose(presetn) |-> timer_output_pins == 4'hF)
    else $error("outputs not idle after reset");
endmodule

// ===== verification/pin_partner.sv
// Partner model: drives timer input and gate pins.
// Assumes pclk from the bench; pins change just after rising edges.
`timescale 1ns/10ps
module pin_partner
(
  input  wire logic pclk,
  output logic [3:0] in_pins,
  output logic       gate_one,
  output logic       gate_two
);
  initial
  begin
    in_pins  = 4'h0;
    gate_one = 1'b0;
    gate_two = 1'b0;
  end
  // Level held n cycles so the synchroniser sees it once
  task automatic set_in(input int i, input logic v, input int n);
    @(posedge pclk);
    in_pins[i] <= v;
    repeat (n) @(posedge pclk);
  endtask
  // Low lets the pair count, high holds it
  task automatic set_gate(input logic g, input logic v);
    @(posedge pclk);
    if (g)
      gate_two <= v;
    else
      gate_one <= v;
  endtask
endmodule

// ===== verification/quad_gated_timer_unit_tb_top.sv
// Self-checking bench of the quad gated timer unit.
// Assumes timer_params.svh on the include path.
`timescale 1ns/10ps
`include "timer_params.svh"
module quad_gated_timer_unit_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic        gate_one, gate_two;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  in_pins, outs;
  int          failures, num_checks;
  quad_gated_timer_unit u_quad_gated_timer_unit (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer_input_pins(in_pins), .gate_pin_first_pair(gate_one),
    .gate_pin_second_pair(gate_two), .timer_output_pins(outs), .irq(irq));
  pin_partner u_pin_partner (.pclk(pclk), .in_pins(in_pins), .gate_one(gate_one), .gate_two(gate_two));
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // --------------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask
  // Idle cycle after each transfer keeps drivers from clashing
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
    begin
      failures++;
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask
  function automatic logic [11:0] ta(input int i, input logic [3:0] o);
    return `OFS_TIMER_BASE + 12'(i) * `OFS_TIMER_STEP + 12'(o);
  endfunction
  function automatic logic [31:0] md(input timer_pkg::source_type s, input timer_pkg::capture_edge_type c,
                                     input logic tg, input logic rs);
    return {26'h000_0000, rs, tg, c, s};
  endfunction
  task automatic wait_low(input int i);
    int n;
    n = 0;
    while (outs[i] !== 1'b0 && n < 60)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 60)
    begin
      failures++;
      final_report();
    end
  endtask
  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic test_regs();
    rdc(`OFS_CTRL, 32'h0000_0000);
    rdc(`OFS_MASK, 32'h0000_0000);
    for (int i = 0; i < 4; i++)
      rdc(ta(i, `OFS_T_REF), 32'h0000_FFFF);
    apb(1'b0, 12'h100, 32'h0000_0000);
    chk(32'(err), 32'h0000_0001);
    $display("regs done");
  endtask
  task automatic test_match(input int i, input logic tg);
    wr(ta(i, `OFS_T_REF), 32'h0000_0005);
    wr(ta(i, `OFS_T_MODE), md(timer_pkg::SRC_CLOCK, timer_pkg::CAP_NONE, tg, 1'b1));
    wr(`OFS_MASK, 32'h0000_0001 << i);
    wr(`OFS_CTRL, 32'h0000_0001 << i);
    wait_low(i);
    @(posedge pclk);
    chk(32'(outs[i]), 32'(!tg));
    chk(32'(irq), 32'h0000_0001);
    wr(`OFS_CTRL, 32'h0000_0000);
    wr(`OFS_STATUS, 32'h0000_00FF);
    chk(32'(irq), 32'h0000_0000);
    wr(`OFS_MASK, 32'h0000_0000);
    $display("match done");
  endtask
  task automatic test_capture();
    wr(`OFS_CTRL, 32'h0000_0001);
    for (int e = 1; e < 4; e++)
    begin
      wr(ta(0, `OFS_T_MODE), md(timer_pkg::SRC_CLOCK, timer_pkg::capture_edge_type'(e), 1'b0, 1'b0));
      wr(`OFS_STATUS, 32'h0000_00FF);
      u_pin_partner.set_in(0, 1'b1, 8);
      apb(1'b0, `OFS_STATUS, 32'h0000_0000);
      chk(32'(rd[4]), 32'(e != 2));
      wr(`OFS_STATUS, 32'h0000_00FF);
      u_pin_partner.set_in(0, 1'b0, 8);
      apb(1'b0, `OFS_STATUS, 32'h0000_0000);
      chk(32'(rd[4]), 32'(e != 1));
    end
    wr(`OFS_CTRL, 32'h0000_0000);
    $display("capture done");
  endtask
  task automatic test_count();
    for (int i = 2; i < 4; i++)
    begin
      wr(ta(i, `OFS_T_REF), 32'h0000_FFFF);
      wr(ta(i, `OFS_T_CNT), 32'h0000_0000);
    end
    wr(ta(3, `OFS_T_MODE), md(timer_pkg::SRC_PIN, timer_pkg::CAP_NONE, 1'b0, 1'b0));
    wr(ta(2, `OFS_T_MODE), md(timer_pkg::SRC_CLOCK_DIV, timer_pkg::CAP_NONE, 1'b0, 1'b0));
    wr(`OFS_CTRL, 32'h0000_000C);
    repeat (3)
    begin
      u_pin_partner.set_in(3, 1'b1, 6);
      u_pin_partner.set_in(3, 1'b0, 6);
    end
    repeat (120) @(posedge pclk);
    wr(`OFS_CTRL, 32'h0000_0000);
    rdc(ta(3, `OFS_T_CNT), 32'h0000_0003);
    apb(1'b0, ta(2, `OFS_T_CNT), 32'h0000_0000);
    chk(32'(rd >= 9 && rd <= 11), 32'h0000_0001);
    $display("count done");
  endtask
  task automatic test_gate();
    logic [31:0] c3;
    wr(ta(0, `OFS_T_CNT), 32'h0000_0100);
    wr(ta(0, `OFS_T_MODE), md(timer_pkg::SRC_CLOCK, timer_pkg::CAP_NONE, 1'b0, 1'b0));
    wr(ta(2, `OFS_T_MODE), md(timer_pkg::SRC_CLOCK, timer_pkg::CAP_NONE, 1'b0, 1'b0));
    wr(`OFS_GATE, 32'h0000_0015);
    u_pin_partner.set_gate(1'b0, 1'b1);
    repeat (6) @(posedge pclk);
    wr(`OFS_CTRL, 32'h0000_0005);
    repeat (10) @(posedge pclk);
    rdc(ta(0, `OFS_T_CNT), 32'h0000_0100);
    apb(1'b0, ta(2, `OFS_T_CNT), 32'h0000_0000);
    c3 = rd;
    apb(1'b0, ta(2, `OFS_T_CNT), 32'h0000_0000);
    chk(32'(rd != c3), 32'h0000_0001);
    u_pin_partner.set_gate(1'b0, 1'b0);
    repeat (12) @(posedge pclk);
    apb(1'b0, ta(0, `OFS_T_CNT), 32'h0000_0000);
    chk(32'(rd < 32'h0000_0100), 32'h0000_0001);
    wr(`OFS_CTRL, 32'h0000_0000);
    wr(`OFS_GATE, 32'h0000_0000);
    $display("gate done");
  endtask
  // Fresh reset so earlier toggles leave no low outputs behind
  task automatic test_cascade();
    int lo;
    int seen;
    lo = 0;
    seen = 0;
    do_reset();
    wr(ta(0, `OFS_T_REF), 32'h0000_0003);
    wr(ta(0, `OFS_T_MODE), md(timer_pkg::SRC_CLOCK, timer_pkg::CAP_NONE, 1'b0, 1'b1));
    wr(ta(1, `OFS_T_REF), 32'h0000_0002);
    wr(ta(1, `OFS_T_MODE), md(timer_pkg::SRC_CHAIN, timer_pkg::CAP_NONE, 1'b0, 1'b1));
    wr(`OFS_CTRL, 32'h0000_0013);
    for (int n = 0; n < 40; n++)
    begin
      @(posedge pclk);
      lo += (outs[0] !== 1'b1);
      seen += (outs[1] === 1'b0);
    end
    chk(32'(lo), 32'h0000_0000);
    chk(32'(seen > 0), 32'h0000_0001);
    // Without cascade the lower pin pulses again and the upper uses the chain source
    wr(`OFS_CTRL, 32'h0000_0003);
    wait_low(0);
    chk(32'(outs[0]), 32'h0000_0000);
    wr(`OFS_CTRL, 32'h0000_0000);
    $display("cascade done");
  endtask
  initial
  begin
    failures = 0;
    num_checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    do_reset();
    test_regs();
    for (int i = 0; i < 4; i++)
      test_match(i, i[0]);
    test_capture();
    test_count();
    test_gate();
    test_cascade();
    final_report();
  end
  initial
  begin
    repeat (100000) @(posedge pclk);
    failures++;
    final_report();
  end
endmodule
bind quad_gated_timer_unit quad_gated_timer_unit_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .timer_output_pins(timer_output_pins), .irq(irq));
